// ==== hdl/sor_top.sv ====
/*
 * Startup options register with its AHB-Lite slave, a startup phase
 * stepper steered by it, completion pin control and capture gating.
 * Assumes one system clock; startup clocks arrive as pin levels and are
 * turned into ticks after synchronisation.
 */
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "sor_regs.svh"

// Notes on behaviour
// - Bit 27 set turns the completion pin into a powerdown status pin.
// - Bit 25 set, the default, adds one register on the completion input.
// - With that stage, the sequencer waits on completion one tick late.
// - Bit 24 clear gives open drain; set drives the pin high actively.
// - Bit 23 clear reloads capture on every request or command.
// - Field 22:17 selects the master configuration clock frequency.
// - Field 16:15 picks sequencer clock: config, user, or JTAG clock.
// - Field 14:12 codes 0 to 5 release completion in phases one to six.
// - Completion release code 111 keeps the pin in its current state.
// - Field 11:9 stalls that phase until calibration matches; 111 none.
// - Field 8:6 stalls that phase until clock managers lock; 111 none.
// - Field 5:3 releases tristate in phases 1-6, 110 tracks, 111 keeps.
// - Field 2:0 releases write disable likewise, 110 tracks, 111 keeps.
module sor_top (
  input wire logic I_SYS_CLK,           // System clock, 10 MHz
  input wire logic I_RESET,             // Synchronous reset, active high
  input wire logic I_HSEL,              // Slave select
  input wire logic [31:0] I_HADDR,      // Byte address
  input wire logic [1:0] I_HTRANS,      // Transfer type
  input wire logic I_HWRITE,            // Write when high
  input wire logic [2:0] I_HSIZE,       // Transfer size
  input wire logic [31:0] I_HWDATA,     // Write data
  input wire logic I_HREADY,            // Bus ready
  output var logic [31:0] O_HRDATA,     // Read data
  output var logic O_HREADYOUT,         // Slave ready
  output var logic O_HRESP,             // Response, always OKAY
  input wire logic I_STARTUP_GO,        // Start the startup sequence
  input wire logic I_CONFIG_CLOCK,      // Configuration clock pin
  input wire logic I_USER_LOGIC_CLOCK,  // User clock at capture primitive
  input wire logic I_JTAG_CLOCK,        // JTAG clock pin
  input wire logic I_COMPLETION_IN,     // Completion pin level
  input wire logic I_CALIB_MATCH,       // Termination calibration matched
  input wire logic I_CLOCK_MGR_LOCK,    // All clock managers locked
  input wire logic I_POWERDOWN,         // Device in powerdown
  input wire logic I_CAPTURE_REQUEST,   // Capture request from user logic
  output var logic O_COMPLETION_OUT,    // Completion pin drive value
  output var logic O_COMPLETION_OE,     // Completion pin drive enable
  output var logic O_GLOBAL_TRISTATE,   // High keeps user pins tristated
  output var logic O_GLOBAL_WRITE_EN,   // High lets user state be written
  output var logic [5:0] O_MASTER_CLOCK_FREQ_SEL, // Master clock select
  output var logic O_CAPTURE_LOAD,      // One-cycle capture load pulse
  output var logic O_END_OF_STARTUP     // Sequence finished
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] sync_lvl;

  sor_sync #(.W(NSYNC)) u_sync (
    .i_clk(I_SYS_CLK),
    .i_reset(I_RESET),
    .i_async({I_CAPTURE_REQUEST, I_POWERDOWN, I_CLOCK_MGR_LOCK,
              I_CALIB_MATCH, I_COMPLETION_IN, I_JTAG_CLOCK,
              I_USER_LOGIC_CLOCK, I_CONFIG_CLOCK}),
    .o_level(sync_lvl)
  );

  logic [2:0] clk_lvl;
  logic completion_input;
  logic match_lvl;
  logic lock_lvl;
  logic pwrdn_lvl;
  logic cap_lvl;
  assign clk_lvl = sync_lvl[2:0];
  assign completion_input = sync_lvl[3];
  assign match_lvl = sync_lvl[4];
  assign lock_lvl = sync_lvl[5];
  assign pwrdn_lvl = sync_lvl[6];
  assign cap_lvl = sync_lvl[7];

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  sor_pkg::sor_aphase_t aph_ff;
  sor_pkg::sor_aphase_t nxt_aph;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic hready_ff;
  logic hresp_ff;
  sor_pkg::sor_opts_t opts_ff;
  sor_pkg::sor_opts_t nxt_opts;
  logic wr_opts;
  logic wr_cmd;
  logic [31:0] status_word;

  // Zero wait states, so the slave is always ready
  always_comb begin
    nxt_aph.valid = I_HSEL & I_HTRANS[1] & I_HREADY;
    nxt_aph.write = I_HWRITE;
    nxt_aph.addr = I_HADDR[9:0];
    nxt_rdata = 32'h0000_0000;
    if (nxt_aph.valid && !I_HWRITE) begin
      case (I_HADDR[9:0])
        `SOR_OPTS_ADDR: nxt_rdata = opts_ff & `SOR_OPTS_WMASK;
        `SOR_STAT_ADDR: nxt_rdata = status_word;
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      aph_ff <= '0;
      rdata_ff <= 32'h0000_0000;
      hready_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      aph_ff <= nxt_aph;
      rdata_ff <= nxt_rdata;
      hready_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  assign wr_opts = aph_ff.valid & aph_ff.write &
                   (aph_ff.addr == `SOR_OPTS_ADDR);
  assign wr_cmd = aph_ff.valid & aph_ff.write &
                  (aph_ff.addr == `SOR_CMD_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Options word
  always_comb begin
    nxt_opts = opts_ff;
    if (wr_opts) begin
      nxt_opts = I_HWDATA & `SOR_OPTS_WMASK;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      opts_ff <= `SOR_OPTS_RESET;
    end else begin
      opts_ff <= nxt_opts;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer clock selection
  logic [2:0] clk_prev_ff;
  logic tick_ff;
  logic nxt_tick;
  logic sel_rise;

  always_comb begin
    case (opts_ff.sequencer_clock_source)
      2'b00: sel_rise = clk_lvl[0] & ~clk_prev_ff[0];
      2'b01: sel_rise = clk_lvl[1] & ~clk_prev_ff[1];
      default: sel_rise = clk_lvl[2] & ~clk_prev_ff[2];
    endcase
    nxt_tick = sel_rise;
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      clk_prev_ff <= 3'h0;
      tick_ff <= 1'b0;
    end else begin
      clk_prev_ff <= clk_lvl;
      tick_ff <= nxt_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Startup phase stepper
  sor_pkg::sor_phase_t phase_ff;
  sor_pkg::sor_phase_t nxt_phase;
  logic run_ff;
  logic nxt_run;
  logic eos_ff;
  logic nxt_eos;
  logic done_pipe_ff;
  logic nxt_done_pipe;
  logic done_seen;
  logic done_rel_ff;
  logic nxt_done_rel;
  logic stall;
  logic [2:0] done_code;

  assign done_code = opts_ff.done_release_phase;

  assign done_seen = opts_ff.done_pipe ? done_pipe_ff : completion_input;

  // Release when entering the selected phase, codes 0..5 meaning 1..6
  function automatic logic rel_at(input logic [2:0] code,
                                  input logic [2:0] ph);
    rel_at = (code <= 3'h5) && (ph >= code + 3'h1);
  endfunction

  always_comb begin
    nxt_phase = phase_ff;
    nxt_run = run_ff;
    nxt_eos = eos_ff;
    nxt_done_pipe = done_pipe_ff;
    nxt_done_rel = done_rel_ff;
    stall = 1'b0;
    if (opts_ff.match_wait_phase != `SOR_CODE_NONE &&
        opts_ff.match_wait_phase == phase_ff && !match_lvl) begin
      stall = 1'b1;
    end
    if (opts_ff.lock_wait_phase != `SOR_CODE_NONE &&
        opts_ff.lock_wait_phase == phase_ff && !lock_lvl) begin
      stall = 1'b1;
    end
    // hold after release until completion seen high
    if (done_rel_ff && !done_seen && done_code <= 3'h5 &&
        phase_ff == sor_pkg::sor_phase_t'(done_code + 3'h1)) begin
      stall = 1'b1;
    end
    if (I_STARTUP_GO && !run_ff) begin
      nxt_run = 1'b1;
      nxt_eos = 1'b0;
      nxt_phase = sor_pkg::SOR_PH0;
      nxt_done_rel = 1'b0;
    end else if (run_ff && tick_ff) begin
      nxt_done_pipe = completion_input;
      if (!stall) begin
        case (phase_ff)
          sor_pkg::SOR_PH0: nxt_phase = sor_pkg::SOR_PH1;
          sor_pkg::SOR_PH1: nxt_phase = sor_pkg::SOR_PH2;
          sor_pkg::SOR_PH2: nxt_phase = sor_pkg::SOR_PH3;
          sor_pkg::SOR_PH3: nxt_phase = sor_pkg::SOR_PH4;
          sor_pkg::SOR_PH4: nxt_phase = sor_pkg::SOR_PH5;
          sor_pkg::SOR_PH5: nxt_phase = sor_pkg::SOR_PH6;
          sor_pkg::SOR_PH6: nxt_phase = sor_pkg::SOR_PH7;
          sor_pkg::SOR_PH7: begin
            nxt_run = 1'b0;
            nxt_eos = 1'b1;
          end
          default: nxt_phase = sor_pkg::SOR_PH0;
        endcase
      end
      // codes 110 and 111 keep current state
      if (rel_at(done_code, nxt_phase)) begin
        nxt_done_rel = 1'b1;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      phase_ff <= sor_pkg::SOR_PH0;
      run_ff <= 1'b0;
      eos_ff <= 1'b0;
      done_pipe_ff <= 1'b0;
      done_rel_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      run_ff <= nxt_run;
      eos_ff <= nxt_eos;
      done_pipe_ff <= nxt_done_pipe;
      done_rel_ff <= nxt_done_rel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and global signal drive
  logic pin_out_ff;
  logic nxt_pin_out;
  logic pin_oe_ff;
  logic nxt_pin_oe;
  logic gts_ff;
  logic nxt_gts;
  logic gwe_ff;
  logic nxt_gwe;
  logic [5:0] freq_ff;
  logic [5:0] nxt_freq;
  logic pin_high;

  always_comb begin
    if (opts_ff.powerdown_status_select) begin
      pin_high = ~pwrdn_lvl;
    end else begin
      pin_high = done_rel_ff;
    end
    // open drain unless drive bit set
    if (!pin_high) begin
      nxt_pin_oe = 1'b1;
      nxt_pin_out = 1'b0;
    end else begin
      nxt_pin_oe = opts_ff.drive_done;
      nxt_pin_out = 1'b1;
    end
    case (opts_ff.tristate_release_phase)
      `SOR_CODE_TRACK: nxt_gts = ~done_seen;
      `SOR_CODE_NONE: nxt_gts = gts_ff;
      default: nxt_gts = gts_ff &
        ~(run_ff && rel_at(opts_ff.tristate_release_phase, phase_ff));
    endcase
    case (opts_ff.write_enable_release_phase)
      `SOR_CODE_TRACK: nxt_gwe = done_seen;
      `SOR_CODE_NONE: nxt_gwe = gwe_ff;
      default: nxt_gwe = gwe_ff |
        (run_ff && rel_at(opts_ff.write_enable_release_phase, phase_ff));
    endcase
    if (I_STARTUP_GO && !run_ff) begin
      nxt_gts = 1'b1;
      nxt_gwe = 1'b0;
    end
    nxt_freq = opts_ff.master_clock_freq_select;
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b1;
      gts_ff <= 1'b1;
      gwe_ff <= 1'b0;
      freq_ff <= 6'h00;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
      gts_ff <= nxt_gts;
      gwe_ff <= nxt_gwe;
      freq_ff <= nxt_freq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture gating
  logic cap_prev_ff;
  logic armed_ff;
  logic nxt_armed;
  logic load_ff;
  logic nxt_load;
  logic cap_event;

  assign cap_event = (cap_lvl & ~cap_prev_ff) |
                     (wr_cmd && I_HWDATA[4:0] == `SOR_CMD_GLOBAL_CAPTURE_COMMAND);

  always_comb begin
    nxt_armed = armed_ff;
    nxt_load = 1'b0;
    if (cap_event && (!opts_ff.single_shot || armed_ff)) begin
      nxt_load = 1'b1;
      nxt_armed = ~opts_ff.single_shot;
    end
    // rearm from host, wins over a same-cycle capture
    if (wr_cmd && I_HWDATA[4:0] == `SOR_CMD_REARM) begin
      nxt_armed = 1'b1;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      cap_prev_ff <= 1'b0;
      armed_ff <= 1'b1;
      load_ff <= 1'b0;
    end else begin
      cap_prev_ff <= cap_lvl;
      armed_ff <= nxt_armed;
      load_ff <= nxt_load;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word and outputs
  assign status_word = {20'h00000, armed_ff, gwe_ff, gts_ff, lock_lvl,
                        match_lvl, done_seen, done_rel_ff, eos_ff,
                        run_ff, phase_ff};

  assign O_HRDATA = rdata_ff;
  assign O_HREADYOUT = hready_ff;
  assign O_HRESP = hresp_ff;
  assign O_COMPLETION_OUT = pin_out_ff;
  assign O_COMPLETION_OE = pin_oe_ff;
  assign O_GLOBAL_TRISTATE = gts_ff;
  assign O_GLOBAL_WRITE_EN = gwe_ff;
  assign O_MASTER_CLOCK_FREQ_SEL = freq_ff;
  assign O_CAPTURE_LOAD = load_ff;
  assign O_END_OF_STARTUP = eos_ff;

endmodule

`default_nettype wire

// ==== hdl/sor_regs.svh ====
/*
 * Register map, field positions, reset values and command codes of the
 * startup options block. Assumes a 32-bit register slave decoding byte addresses.
 */
`ifndef SOR_REGS_SVH
`define SOR_REGS_SVH

// Printed index of the options word; byte address is four times it
`define SOR_OPTS_IDX 8'h09
`define SOR_OPTS_ADDR 10'h024
`define SOR_CMD_ADDR 10'h010
`define SOR_STAT_ADDR 10'h028

`define SOR_OPTS_RESET 32'h0200_3fec
// Bits that hold storage; reserved 31:28 and 26 stay zero
`define SOR_OPTS_WMASK 32'h0bff_ffff

`define SOR_POS_PWRDN 27
`define SOR_POS_PIPE 25
`define SOR_POS_DRIVE 24
`define SOR_POS_SINGLE 23
`define SOR_POS_FREQ 17
`define SOR_POS_SRC 15
`define SOR_POS_DONE 12
`define SOR_POS_MATCH 9
`define SOR_POS_LOCK 6
`define SOR_POS_TRI 3
`define SOR_POS_WREN 0

`define SOR_CMD_GLOBAL_CAPTURE_COMMAND 5'h01
`define SOR_CMD_REARM 5'h02

`define SOR_CODE_TRACK 3'h6
`define SOR_CODE_NONE 3'h7

`endif

// ==== hdl/sor_pkg.sv ====
/*
 * Types shared by the startup options block.
 * Assumes the constants of sor_regs.svh.
 */
package sor_pkg;

  typedef enum logic [2:0] {
    SOR_PH0 = 3'b000,
    SOR_PH1 = 3'b001,
    SOR_PH2 = 3'b010,
    SOR_PH3 = 3'b011,
    SOR_PH4 = 3'b100,
    SOR_PH5 = 3'b101,
    SOR_PH6 = 3'b110,
    SOR_PH7 = 3'b111
  } sor_phase_t;

  // Layout of the options word, msb first
  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic powerdown_status_select;
    logic rsvd_26;
    logic done_pipe;
    logic drive_done;
    logic single_shot;
    logic [5:0] master_clock_freq_select;
    logic [1:0] sequencer_clock_source;
    logic [2:0] done_release_phase;
    logic [2:0] match_wait_phase;
    logic [2:0] lock_wait_phase;
    logic [2:0] tristate_release_phase;
    logic [2:0] write_enable_release_phase;
  } sor_opts_t;

  // Captured address phase of a bus transfer
  typedef struct packed {
    logic valid;
    logic write;
    logic [9:0] addr;
  } sor_aphase_t;

endpackage

// ==== hdl/sor_sync.sv ====
/*
 * Three-stage input synchroniser, one lane per bit.
 * Assumes asynchronous inputs; level moves once stages two and three agree.
 */
`timescale 1ns/10ps
`default_nettype none

module sor_sync #(
  parameter int W = 8
) (
  input wire logic i_clk,            // System clock
  input wire logic i_reset,          // Synchronous reset, active high
  input wire logic [W-1:0] i_async,  // Raw pin levels
  output var logic [W-1:0] o_level   // Filtered level
);

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_lane
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic lvl_ff;
      logic nxt_lvl;
      always_comb begin
        nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
      end
      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
          lvl_ff <= 1'b0;
        end else begin
          s1_ff <= i_async[g];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          lvl_ff <= nxt_lvl;
        end
      end
      assign o_level[g] = lvl_ff;
    end
  endgenerate

endmodule

`default_nettype wire

// ==== verification/sor_top_asserts.sv ====
/*
 * Checker for the startup options block: bus answers, capture pulse,
 * completion pin drive and the clock select copy.
 * Assumes it is bound to sor_top and sees only its ports.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sor_regs.svh"

module sor_top_asserts (
  input wire logic I_SYS_CLK,         // System clock
  input wire logic I_RESET,           // Sync reset, active high
  input wire logic I_HSEL,            // Slave select
  input wire logic [31:0] I_HADDR,    // Byte address
  input wire logic [1:0] I_HTRANS,    // Transfer type
  input wire logic I_HWRITE,          // Write when high
  input wire logic [31:0] I_HWDATA,   // Write data
  input wire logic I_HREADY,          // Bus ready
  input wire logic [31:0] O_HRDATA,   // Read data
  input wire logic O_HREADYOUT,       // Slave ready
  input wire logic O_HRESP,           // Response
  input wire logic O_COMPLETION_OUT,  // Pin drive value
  input wire logic O_COMPLETION_OE,   // Pin drive enable
  input wire logic [5:0] O_MASTER_CLOCK_FREQ_SEL, // Clock select
  input wire logic O_CAPTURE_LOAD     // Capture load pulse
);
  logic take;
  logic wo_ff, ro_ff, rz_ff, rd_ff, wc_ff, single_ff;
  logic nxt_wo, nxt_ro, nxt_rz, nxt_rd, nxt_wc, nxt_single;

  ////////////////////////////////////////////////////////////////////////
  // Data phase trackers; single_ff shadows the single-shot bit
  always_comb begin
    take = I_HSEL && I_HTRANS[1] && I_HREADY;
    nxt_wo = take && I_HWRITE && I_HADDR[9:0] == `SOR_OPTS_ADDR;
    nxt_ro = take && !I_HWRITE && I_HADDR[9:0] == `SOR_OPTS_ADDR;
    nxt_rz = take && !I_HWRITE && I_HADDR[9:0] != `SOR_OPTS_ADDR &&
      I_HADDR[9:0] != `SOR_STAT_ADDR;
    nxt_rd = take && !I_HWRITE;
    nxt_wc = take && I_HWRITE && I_HADDR[9:0] == `SOR_CMD_ADDR;
    nxt_single = wo_ff ? I_HWDATA[`SOR_POS_SINGLE] : single_ff;
    if (I_RESET) begin
      {nxt_wo, nxt_ro, nxt_rz, nxt_rd, nxt_wc, nxt_single} = 6'h00;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    {wo_ff, ro_ff, rz_ff, rd_ff, wc_ff, single_ff} <=
      {nxt_wo, nxt_ro, nxt_rz, nxt_rd, nxt_wc, nxt_single};
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RESET);

  sequence s_cmd_cap;
    wc_ff && !single_ff && I_HWDATA[4:0] == `SOR_CMD_GLOBAL_CAPTURE_COMMAND;
  endsequence
  sequence s_pulse;
    O_CAPTURE_LOAD ##1 !O_CAPTURE_LOAD;
  endsequence

  chk_cmd_capture: assert property (s_cmd_cap |=> s_pulse)
    else $error("capture command gave no load pulse");
  chk_load_pulse: assert property (O_CAPTURE_LOAD |=> !O_CAPTURE_LOAD)
    else $error("capture load longer than one cycle");
  chk_freq_copy: assert property (wo_ff |-> ##2
    O_MASTER_CLOCK_FREQ_SEL == $past(I_HWDATA[`SOR_POS_FREQ +: 6], 2))
    else $error("clock select does not follow the written field");
  chk_rsvd_zero: assert property (ro_ff |->
    O_HRDATA[31:28] == 4'h0 && !O_HRDATA[26])
    else $error("reserved option bits read nonzero");
  chk_unmapped_zero: assert property (rz_ff |-> O_HRDATA == 32'h0)
    else $error("write-only or unmapped read nonzero");
  chk_idle_rdata: assert property (!rd_ff |-> O_HRDATA == 32'h0)
    else $error("read data outside a read data phase");
  chk_ready_okay: assert property (O_HREADYOUT && !O_HRESP)
    else $error("slave stalled or answered with error");
  chk_pin_release: assert property (
    !O_COMPLETION_OE |-> O_COMPLETION_OUT)
    else $error("released completion pin not at high value");
endmodule

bind sor_top sor_top_asserts chk_u (.I_SYS_CLK, .I_RESET, .I_HSEL,
  .I_HADDR, .I_HTRANS, .I_HWRITE, .I_HWDATA, .I_HREADY, .O_HRDATA,
  .O_HREADYOUT, .O_HRESP, .O_COMPLETION_OUT, .O_COMPLETION_OE,
  .O_MASTER_CLOCK_FREQ_SEL, .O_CAPTURE_LOAD);

`default_nettype wire

// ==== verification/tb_top.sv ====
/*
 * Self-checking bench for sor_top: option register, capture gating
 * and the startup phase stepper, all through the AHB-Lite slave.
 * Assumes the checker is bound to sor_top from its own file.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sor_regs.svh"

module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] ck = 3'h0;
  logic cin = 1'b0, calib = 1'b1, lock = 1'b1, pwr = 1'b0, capreq = 1'b0;
  logic hready, hresp, cout, coe, gtri, gwen, cload, eos;
  logic [5:0] freq;
  int num_errors = 0, tests_run = 0, cyc = 0, loads = 0, exp_loads = 0;

  always #50 clk = ~clk;

  sor_top dut_u (.I_SYS_CLK(clk), .I_RESET(rst), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .I_STARTUP_GO(go), .I_CONFIG_CLOCK(ck[0]),
    .I_USER_LOGIC_CLOCK(ck[1]), .I_JTAG_CLOCK(ck[2]),
    .I_COMPLETION_IN(cin), .I_CALIB_MATCH(calib),
    .I_CLOCK_MGR_LOCK(lock), .I_POWERDOWN(pwr),
    .I_CAPTURE_REQUEST(capreq), .O_COMPLETION_OUT(cout),
    .O_COMPLETION_OE(coe), .O_GLOBAL_TRISTATE(gtri),
    .O_GLOBAL_WRITE_EN(gwen), .O_MASTER_CLOCK_FREQ_SEL(freq),
    .O_CAPTURE_LOAD(cload), .O_END_OF_STARTUP(eos));

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Load pulses counted here so a task never misses a one-cycle pulse
  always @(posedge clk) begin
    if (cload === 1'b1)
      loads++;
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One single transfer; read data taken at the edge ending the data phase
  task automatic xfer(input logic w, input logic [9:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rdata = hrdata;
  endtask

  task automatic rd_chk(input string n, input logic [9:0] a,
                        input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rdata);
  endtask

  // Pin clocks keep each level well over three system cycles
  task automatic step(input int s, input logic [2:0] p);
    ck[s] <= 1'b1;
    wt(5);
    ck[s] <= 1'b0;
    wt(8);
    xfer(1'b0, `SOR_STAT_ADDR, 32'h0);
    chk("phase", {29'h0, p}, {29'h0, rdata[2:0]});
  endtask

  task automatic req();
    capreq <= 1'b1;
    wt(8);
    capreq <= 1'b0;
    wt(8);
  endtask

  task automatic loads_chk(input int n);
    wt(4);
    exp_loads += n;
    chk("loads", exp_loads, loads);
  endtask

  task automatic start();
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    wt(2);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    wt(10);
    rst <= 1'b0;
    wt(1);
    chk("pin", 32'h2, {30'h0, coe, cout});
    chk("gates", 32'h2, {30'h0, gtri, gwen});
    chk("eos load", 32'h0, {30'h0, eos, cload});
    rd_chk("opts", `SOR_OPTS_ADDR, 32'h0200_3fec);
    xfer(1'b1, `SOR_OPTS_ADDR, 32'hffff_ffff);
    rd_chk("opts", `SOR_OPTS_ADDR, 32'h0bff_ffff);
    chk("freq", 32'h3f, {26'h0, freq});
    xfer(1'b1, `SOR_OPTS_ADDR, 32'h0054_0000);
    rd_chk("opts", `SOR_OPTS_ADDR, 32'h0054_0000);
    chk("freq", 32'h2a, {26'h0, freq});
    xfer(1'b1, 10'h030, 32'hffff_ffff);
    rd_chk("unmapped", 10'h030, 32'h0);
    rd_chk("cmd", `SOR_CMD_ADDR, 32'h0);
    // Repeated capture, then single-shot with rearm
    xfer(1'b1, `SOR_CMD_ADDR, {27'h0, `SOR_CMD_GLOBAL_CAPTURE_COMMAND});
    loads_chk(1);
    req();
    loads_chk(1);
    req();
    loads_chk(1);
    xfer(1'b1, `SOR_OPTS_ADDR, 32'h0080_0000);
    xfer(1'b1, `SOR_CMD_ADDR, {27'h0, `SOR_CMD_REARM});
    req();
    loads_chk(1);
    req();
    loads_chk(0);
    xfer(1'b1, `SOR_CMD_ADDR, {27'h0, `SOR_CMD_GLOBAL_CAPTURE_COMMAND});
    loads_chk(0);
    xfer(1'b1, `SOR_CMD_ADDR, {27'h0, `SOR_CMD_REARM});
    req();
    loads_chk(1);
    // Full run: done phase 2, tristate phase 1, write enable phase 3
    cin <= 1'b1;
    xfer(1'b1, `SOR_OPTS_ADDR, 32'h0000_1fc2);
    start();
    for (int p = 1; p < 8; p++) begin
      step(0, p[2:0]);
      chk("gates", {31'h0, p >= 3}, {30'h0, gtri, gwen});
      chk("pin", {30'h0, p < 2, p >= 2}, {30'h0, coe, cout});
    end
    // Sequencer parks in phase 7 once the run ends
    step(0, 3'h7);
    chk("eos", 32'h1, {31'h0, eos});
    // Stalls: user clock, pipe on, driven pin, match 3, lock 4, keep
    xfer(1'b1, `SOR_OPTS_ADDR, 32'h0300_873f);
    cin <= 1'b0;
    calib <= 1'b0;
    lock <= 1'b0;
    start();
    chk("eos", 32'h0, {31'h0, eos});
    step(0, 3'h0);
    step(1, 3'h1);
    chk("pin", 32'h3, {30'h0, coe, cout});
    step(1, 3'h1);
    cin <= 1'b1;
    wt(6);
    step(1, 3'h1);
    step(1, 3'h2);
    step(1, 3'h3);
    step(1, 3'h3);
    calib <= 1'b1;
    wt(6);
    step(1, 3'h4);
    step(1, 3'h4);
    lock <= 1'b1;
    wt(6);
    step(1, 3'h5);
    chk("gates", 32'h2, {30'h0, gtri, gwen});
    // Completion pin as powerdown status
    xfer(1'b1, `SOR_OPTS_ADDR, 32'h0a00_3fec);
    pwr <= 1'b1;
    wt(8);
    chk("pwr pin", 32'h2, {30'h0, coe, cout});
    pwr <= 1'b0;
    wt(8);
    chk("pwr pin", 32'h1, {30'h0, coe, cout});
    final_report();
  end
endmodule

`default_nettype wire
